/* core/fta_top.sv */
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
module fta_top
  import fta_pkg::*;
#(
  parameter int REF_DIVIDE = REF_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic first_tach_input,
  input wire logic second_tach_input,
  input wire logic [11:0] tempSample,
  input wire logic tempSampleValid,
  output logic intLine_n,
  output logic overheat_line_n
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] config_;
  logic [7:0] fanDiv;
  logic [3:0] resCtl;
  fta_limits_t lim;
  logic [11:0] tempVal;
  logic [7:0] status1;
  logic [7:0] status2;
  logic [7:0] fanCount [2];
  logic [1:0] fanLevel;
  logic rdDone;
  logic monitorOn;
  assign monitorOn = config_[CFG_START] && !config_[CFG_INTCLR];

  // ---------------------------------------------------------------
  // reference tick
  // ---------------------------------------------------------------
  logic [15:0] refCnt;
  logic refTick;
  assign refTick = (refCnt == 16'(REF_DIVIDE - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refCnt <= 16'h0000;
    end else if (clkEn) begin
      refCnt <= refTick ? 16'h0000 : refCnt + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // fan channels
  // ---------------------------------------------------------------
  logic [1:0] tachRaw;
  assign tachRaw = {second_tach_input, first_tach_input};
  logic [1:0] fanAlarm;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gFan
      logic s1, s2, s3;
      logic [10:0] acc;
      logic [3:0] divN;
      logic [1:0] divSel;
      logic lvlMode;
      logic rise;
      assign divSel = (g == 0) ? fanDiv[FD_DIV1 +: 2] : fanDiv[FD_DIV2 +: 2];
      assign lvlMode = (g == 0) ? fanDiv[FD_F1LVL] : fanDiv[FD_F2LVL];
      // quarter counts per tick: 8, 4, 2, 1 for divisor 1, 2, 4, 8
      assign divN = 4'(4'h8 >> divSel);
      assign rise = s2 && !s3;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else if (clkEn) begin
          s1 <= tachRaw[g];
          s2 <= s1;
          s3 <= s2;
        end
      end
      // one tach period, count falls as divisor rises
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          acc <= 11'h000;
          fanCount[g] <= 8'hff;
          fanAlarm[g] <= 1'b0;
        end else if (clkEn) begin
          fanAlarm[g] <= 1'b0;
          if (!monitorOn || lvlMode) begin
            acc <= 11'h000;
          end else if (rise) begin
            acc <= 11'h000;
            fanCount[g] <= (acc >= 11'(FAN_MAX * 4)) ? 8'hff : acc[9:2];
            fanAlarm[g] <= (acc >= 11'(FAN_MAX * 4));
          end else if (refTick && acc < 11'(FAN_MAX * 4)) begin
            acc <= acc + 11'(divN);
          end
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          fanLevel[g] <= 1'b0;
        end else if (clkEn) begin
          fanLevel[g] <= s2;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // temperature capture and compare
  // ---------------------------------------------------------------
  logic [7:0] tempHi;
  logic hotAbove, hotBelowHyst, ovAbove, ovBelowHyst;
  assign tempHi = tempVal[11:4];
  assign hotAbove = $signed(tempHi) > $signed(lim.hot);
  assign hotBelowHyst = $signed(tempHi) < $signed(lim.hotHyst);
  assign ovAbove = $signed(tempHi) > $signed(lim.ovLim);
  assign ovBelowHyst = $signed(tempHi) < $signed(lim.ovHyst);
  logic ovBelowLim;
  assign ovBelowLim = $signed(tempHi) < $signed(lim.ovLim);

  logic convDone;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tempVal <= 12'h000;
      convDone <= 1'b0;
    end else if (clkEn) begin
      convDone <= 1'b0;
      if (tempSampleValid && monitorOn) begin
        convDone <= 1'b1;
        if (resCtl[RES_WIDE]) begin
          tempVal <= tempSample;
        end else begin
          tempVal <= {tempSample[11:3], 3'b000};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // hot and overheat event logic
  // ---------------------------------------------------------------
  logic hotArmed, ovArmed, ovEvent, hotEvent, ovCompLow;
  logic ovOnce;
  logic rdStatus1, rdStatus2;
  assign ovOnce = resCtl[RES_OVONCE];
  assign hotEvent = convDone && hotAbove &&
                    (hotArmed || !ovOnce);
  assign ovEvent = convDone && ovAbove && ovArmed;

  // hot bit: default mode reasserts each conversion above the hot limit, clears below hysteresis
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hotArmed <= 1'b1;
      ovArmed <= 1'b1;
    end else if (clkEn && convDone) begin
      if (hotAbove) begin
        hotArmed <= 1'b0;
      end else if (hotBelowHyst) begin
        hotArmed <= 1'b1;
      end
      if (ovAbove) begin
        ovArmed <= 1'b0;
      end else if (ovBelowHyst) begin
        ovArmed <= 1'b1;
      end
    end
  end

  // status, set wins over read clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status1 <= 8'h00;
      status2 <= 8'h00;
    end else if (clkEn) begin
      if (hotEvent) begin
        status1[ST1_HOT] <= 1'b1;
      end else if (convDone && hotBelowHyst) begin
        status1[ST1_HOT] <= 1'b0;
      end else if (rdStatus1) begin
        status1[ST1_HOT] <= 1'b0;
      end
      for (int i = 1; i < 8; i++) begin
        if (rdStatus1) begin
          status1[i] <= 1'b0;
        end
      end
      if (fanAlarm[0]) begin
        status1[ST_FIRST_TACH_INPUT] <= 1'b1;
      end
      if (fanAlarm[1]) begin
        status1[ST_SECOND_TACH_INPUT] <= 1'b1;
      end
      if (ovEvent || (convDone && ovAbove && !ovOnce)) begin
        status2[ST2_OV] <= 1'b1;
      end else if (rdStatus2) begin
        status2 <= 8'h00;
      end
    end
  end

  // overheat comparator state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovCompLow <= 1'b0;
    end else if (clkEn && convDone) begin
      // equal to the limit holds the line where it is
      if (ovAbove) begin
        ovCompLow <= 1'b1;
      end else if (ovBelowLim) begin
        ovCompLow <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // output lines
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intLine_n <= 1'b1;
      overheat_line_n <= 1'b1;
    end else if (clkEn) begin
      intLine_n <= !(config_[CFG_INTEN] && !config_[CFG_INTCLR] &&
                     (|status1 || status2[ST2_OV]));
      if (config_[CFG_INTCLR] || !fanDiv[FD_OVEN]) begin
        overheat_line_n <= 1'b1;
      end else if (ovOnce) begin
        overheat_line_n <= !status2[ST2_OV];
      end else begin
        overheat_line_n <= !ovCompLow;
      end
    end
  end

  // ---------------------------------------------------------------
  // avalon slave: one wait cycle, answer on second edge
  // ---------------------------------------------------------------
  logic req;
  assign req = (avs_read || avs_write) && clkEn;
  assign avs_waitrequest = !rdDone;
  assign rdStatus1 = avs_read && rdDone && avs_address == ADDR_STATUS1;
  assign rdStatus2 = avs_read && rdDone && avs_address == ADDR_STATUS2;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdDone <= 1'b0;
    end else begin
      rdDone <= req && !rdDone;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_ <= CFG_RESET;
      fanDiv <= FANDIV_RESET;
      resCtl <= 4'h0;
      lim <= '0;
    end else if (clkEn && avs_write && rdDone) begin
      case (avs_address)
        ADDR_CONFIG: config_ <= avs_writedata[7:0];
        ADDR_FANDIV: fanDiv <= avs_writedata[7:0];
        ADDR_RESCFG: resCtl <= avs_writedata[3:0];
        ADDR_HOT: lim.hot <= avs_writedata[7:0];
        ADDR_HOTHYST: lim.hotHyst <= avs_writedata[7:0];
        ADDR_OVLIM: lim.ovLim <= avs_writedata[7:0];
        ADDR_OVHYST: lim.ovHyst <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  logic [31:0] next_readdata;
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      ADDR_CONFIG: next_readdata[7:0] = config_;
      ADDR_STATUS1: next_readdata[7:0] = status1;
      ADDR_STATUS2: next_readdata[7:0] = status2;
      ADDR_FANDIV: next_readdata[7:0] = fanDiv;
      ADDR_RESCFG: next_readdata[7:0] = {tempVal[3:0], resCtl};
      ADDR_HOT: next_readdata[7:0] = lim.hot;
      ADDR_HOTHYST: next_readdata[7:0] = lim.hotHyst;
      ADDR_OVLIM: next_readdata[7:0] = lim.ovLim;
      ADDR_OVHYST: next_readdata[7:0] = lim.ovHyst;
      ADDR_TEMPHI: next_readdata[7:0] = tempHi;
      ADDR_FAN1CNT: next_readdata[7:0] = fanCount[0];
      ADDR_FAN2CNT: next_readdata[7:0] = fanCount[1];
      ADDR_FANLVL: next_readdata[1:0] = fanLevel;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (req && !rdDone) begin
      avs_readdata <= next_readdata;
    end
  end

endmodule

/* pkg/fta_pkg.sv */
package fta_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS1 = 8'h04;
  localparam logic [7:0] ADDR_STATUS2 = 8'h08;
  localparam logic [7:0] ADDR_FANDIV = 8'h0c;
  localparam logic [7:0] ADDR_RESCFG = 8'h10;
  localparam logic [7:0] ADDR_HOT = 8'h14;
  localparam logic [7:0] ADDR_HOTHYST = 8'h18;
  localparam logic [7:0] ADDR_OVLIM = 8'h1c;
  localparam logic [7:0] ADDR_OVHYST = 8'h20;
  localparam logic [7:0] ADDR_TEMPHI = 8'h28;
  localparam logic [7:0] ADDR_FAN1CNT = 8'h2c;
  localparam logic [7:0] ADDR_FAN2CNT = 8'h30;
  localparam logic [7:0] ADDR_FANLVL = 8'h34;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CFG_START = 0;
  localparam int CFG_INTEN = 1;
  localparam int CFG_INTCLR = 3;
  localparam logic [7:0] CFG_RESET = 8'h08;
  localparam int RES_OVONCE = 2;
  localparam int RES_WIDE = 3;
  localparam int FD_F1LVL = 0;
  localparam int FD_F2LVL = 1;
  localparam int FD_DIV1 = 2;
  localparam int FD_DIV2 = 4;
  localparam int FD_OVEN = 6;
  localparam logic [7:0] FANDIV_RESET = 8'h54;
  localparam int ST1_HOT = 0;
  localparam int ST2_OV = 0;
  localparam int ST_FIRST_TACH_INPUT = 1;
  localparam int ST_SECOND_TACH_INPUT = 2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int REF_HZ = 22500;
  localparam int REF_DIV = CLK_HZ / REF_HZ;
  localparam int FAN_MAX = 255;

  typedef struct packed {
    logic [7:0] hot;
    logic [7:0] hotHyst;
    logic [7:0] ovLim;
    logic [7:0] ovHyst;
  } fta_limits_t;
endpackage

/* verification/fta_assertions.sv */
`timescale 1ns/1ps
module fta_assertions
  import fta_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [11:0] tempSample,
  input wire logic tempSampleValid,
  input wire logic intLine_n,
  input wire logic overheat_line_n
);
  logic [7:0] cfg, ovLim, tHi;
  logic [4:0] vh;
  logic ovOnce, run, ans, hot, cold, smp;
  assign ans = !avs_waitrequest;
  assign run = cfg[CFG_START] && !cfg[CFG_INTCLR] && clkEn;
  assign smp = tempSampleValid && run;
  assign hot = $signed(tempSample[11:4]) > $signed(ovLim);
  assign cold = $signed(tempSample[11:4]) < $signed(ovLim);
  // ----------------
  // register shadow
  // ----------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
      ovLim <= 8'h00;
      ovOnce <= 1'b0;
    end else if (ans && avs_write) begin
      case (avs_address)
        ADDR_CONFIG: cfg <= avs_writedata[7:0];
        ADDR_OVLIM: ovLim <= avs_writedata[7:0];
        ADDR_RESCFG: ovOnce <= avs_writedata[RES_OVONCE];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vh <= 5'h00;
      tHi <= 8'h00;
    end else begin
      vh <= {vh[3:0], smp};
      if (smp) begin
        tHi <= tempSample[11:4];
      end
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rd_hi;
    ans && avs_read |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("high bits");
  property p_temp_rd;
    ans && avs_read && avs_address == ADDR_TEMPHI |-> avs_readdata[7:0] == tHi;
  endproperty
  a_temp_rd: assert property (p_temp_rd) else $error("temp");
  property p_ack;
    ans |-> (avs_read || avs_write) ##1 !ans;
  endproperty
  a_ack: assert property (p_ack) else $error("answer");
  property p_clr;
    cfg[CFG_INTCLR] [*3] |-> intLine_n && overheat_line_n;
  endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_int_cause;
    $fell(intLine_n) |-> (|vh[4:1]) && cfg[CFG_INTEN];
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("int");
  property p_ov_cause;
    $fell(overheat_line_n) |-> |vh[4:1];
  endproperty
  a_ov_cause: assert property (p_ov_cause) else $error("ov fall");
  property p_ov_above;
    smp && !ovOnce && hot |-> ##[2:5] !overheat_line_n;
  endproperty
  a_ov_above: assert property (p_ov_above) else $error("ov lo");
  property p_ov_below;
    smp && !ovOnce && cold |-> ##[2:5] overheat_line_n;
  endproperty
  a_ov_below: assert property (p_ov_below) else $error("ov hi");
endmodule
bind fta_top fta_assertions fta_assertions_inst (.*);

/* verification/fta_partner.sv */
`timescale 1ns/1ps
module fta_partner (
  input wire logic clk,
  input wire logic [1:0][11:0] half,
  input wire logic [1:0] lvl,
  input wire logic req,
  input wire logic [11:0] val,
  output logic [1:0] tach,
  output logic [11:0] sample,
  output logic sampleValid
);
  logic [1:0][11:0] cnt;
  // ----------------
  // fans and sensor
  // ----------------
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (half[i] == 12'h000) begin
        tach[i] <= lvl[i];
        cnt[i] <= 12'h000;
      end else if (cnt[i] + 12'h001 >= half[i]) begin
        tach[i] <= ~tach[i];
        cnt[i] <= 12'h000;
      end else begin
        cnt[i] <= cnt[i] + 12'h001;
      end
    end
  end
  // result only valid in its pulse; scrambled otherwise
  always_ff @(posedge clk) begin
    sampleValid <= req;
    sample <= req ? val : ~sample;
  end
endmodule

/* verification/fta_top_tb.sv */
`timescale 1ns/1ps
module fta_top_tb
  import fta_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic aRd = 1'b0, aWr = 1'b0, req = 1'b0;
  logic [7:0] aAdr = 8'h00, q;
  logic [31:0] aWd = 32'h0, aRdat;
  logic [11:0] val = 12'h000, tSmp;
  logic [1:0][11:0] half = '0;
  logic [1:0] lvl = 2'b00, tach;
  logic aWait, tVld, intL_n, ovL_n;
  int bad_count = 0, tests_run = 0;
  localparam logic [7:0] LIM [5] = '{8'h19, 8'h19, 8'h19, 8'he7, 8'he7};
  localparam logic [11:0] SMP [5] = '{12'h1a0, 12'h190, 12'h180,
    12'hec0, 12'he60};
  localparam logic [4:0] EXP = 5'b10100;
  always #25 clk = ~clk;
  fta_top #(.REF_DIVIDE(4)) fta_top_inst (.clk(clk), .rst_n(rst_n),
    .clkEn(1'b1), .avs_address(aAdr), .avs_read(aRd), .avs_write(aWr),
    .avs_writedata(aWd), .avs_readdata(aRdat), .avs_waitrequest(aWait),
    .first_tach_input(tach[0]), .second_tach_input(tach[1]),
    .tempSample(tSmp), .tempSampleValid(tVld), .intLine_n(intL_n),
    .overheat_line_n(ovL_n));
  fta_partner fta_partner_inst (.clk(clk), .half(half), .lvl(lvl),
    .req(req), .val(val), .tach(tach), .sample(tSmp), .sampleValid(tVld));
  // ----------------
  // shared tasks
  // ----------------
  task check(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %0t saw %h want %h", $time, s, e);
    end
  endtask
  task end_sim;
    $display("checks %0d bad %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    aAdr <= a;
    aWd <= {24'h0, d};
    aWr <= w;
    aRd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (aWait !== 1'b0 && n < 99);
    if (n >= 99) begin
      bad_count++;
      end_sim;
    end
    q = aRdat[7:0];
    aWr <= 1'b0;
    aRd <= 1'b0;
  endtask
  task temp(input logic [11:0] v);
    @(posedge clk);
    val <= v;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task lines(input logic [1:0] e);
    repeat (3) @(negedge clk);
    check({6'h0, intL_n, ovL_n}, {6'h0, e});
  endtask
  function automatic logic [7:0] near(logic [7:0] s, int e);
    return (s + 1 >= e && s <= e + 1) ? 8'h01 : 8'h00;
  endfunction
  // ----------------
  // scenarios
  // ----------------
  task t_reset;
    bus(1'b0, ADDR_CONFIG, 8'h00);
    check(q, CFG_RESET);
    bus(1'b0, ADDR_FANDIV, 8'h00);
    check(q, FANDIV_RESET);
    bus(1'b1, 8'h3c, 8'h5a);
    bus(1'b0, 8'h3c, 8'h00);
    check(q, 8'h00);
    bus(1'b1, ADDR_HOT, 8'h7f);
    bus(1'b1, ADDR_OVLIM, 8'he7);
    bus(1'b0, ADDR_OVLIM, 8'h00);
    check(q, 8'he7);
    bus(1'b1, ADDR_OVLIM, 8'h7f);
    bus(1'b1, ADDR_CONFIG, 8'h01);
  endtask
  task t_fan;
    half <= {12'h0a0, 12'h0a0};
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, ADDR_FANDIV, 8'(8'h40 + (3 - k) * 16 + k * 4));
      repeat (3000) @(posedge clk);
      bus(1'b0, ADDR_FAN1CNT, 8'h00);
      check(near(q, 160 >> k), 8'h01);
      bus(1'b0, ADDR_FAN2CNT, 8'h00);
      check(near(q, 160 >> (3 - k)), 8'h01);
    end
    half <= {12'h320, 12'h320};
    bus(1'b1, ADDR_FANDIV, 8'h40);
    repeat (5000) @(posedge clk);
    bus(1'b0, ADDR_FAN1CNT, 8'h00);
    check(q, 8'hff);
    half <= '0;
    bus(1'b1, ADDR_FANDIV, 8'h43);
    for (int i = 1; i < 3; i++) begin
      lvl <= 2'(i);
      repeat (10) @(posedge clk);
      bus(1'b0, ADDR_FANLVL, 8'h00);
      check(q & 8'h03, 8'(i));
    end
  endtask
  task t_temp;
    bus(1'b1, ADDR_RESCFG, 8'h00);
    temp(12'h19d);
    bus(1'b1, ADDR_TEMPHI, 8'h55);
    bus(1'b0, ADDR_TEMPHI, 8'h00);
    check(q, 8'h19);
    bus(1'b0, ADDR_RESCFG, 8'h00);
    check(q & 8'hf0, 8'h80);
    bus(1'b1, ADDR_RESCFG, 8'h08);
    temp(12'he7d);
    bus(1'b0, ADDR_TEMPHI, 8'h00);
    check(q, 8'he7);
    bus(1'b0, ADDR_RESCFG, 8'h00);
    check(q & 8'hf0, 8'hd0);
    bus(1'b1, ADDR_RESCFG, 8'h00);
  endtask
  task t_cmp;
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, ADDR_OVLIM, LIM[i]);
      temp(SMP[i]);
      check({7'h0, ovL_n}, {7'h0, EXP[i]});
    end
    bus(1'b1, ADDR_OVLIM, 8'h7f);
  endtask
  task t_int;
    bus(1'b1, ADDR_HOT, 8'h1e);
    bus(1'b1, ADDR_HOTHYST, 8'h1c);
    bus(1'b0, ADDR_STATUS1, 8'h00);
    bus(1'b0, ADDR_STATUS2, 8'h00);
    bus(1'b1, ADDR_CONFIG, 8'h03);
    temp(12'h1f0);
    lines(2'b01);
    bus(1'b0, ADDR_STATUS1, 8'h00);
    check(q & 8'h01, 8'h01);
    lines(2'b11);
    bus(1'b0, ADDR_STATUS1, 8'h00);
    check(q & 8'h01, 8'h00);
    temp(12'h1f0);
    lines(2'b01);
    temp(12'h1b0);
    lines(2'b11);
    temp(12'h1f0);
    bus(1'b1, ADDR_CONFIG, 8'h0b);
    lines(2'b11);
    bus(1'b0, ADDR_STATUS1, 8'h00);
    check(q & 8'h01, 8'h01);
    temp(12'h1f0);
    lines(2'b11);
    bus(1'b1, ADDR_CONFIG, 8'h03);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_fan;
    t_temp;
    t_cmp;
    t_int;
    end_sim;
  end
endmodule
